// ==== verilog/apf_fault_top.sv ====
// Functional notes
// [RULE1] shutdown flag low on any shutdown fault
// [RULE2] warning pin low while thermal warning
// [RULE3] two pins encode normal, fault, warning, both
// [RULE4] reset held forces shutdown flag released
// [RULE5] fault makes outputs hi-z, flag low
// [RULE6] undervoltage recovers by itself when gone
// [RULE7] pairs off in bridged, all in parallel
// [RULE8] bootstrap undervoltage: own bridge only, unlatched
// [RULE9] cycle limiting or latched trip, by configuration
// [RULE10] per-bridge flip, cleared at next frame
// [RULE11] counter up per event, down otherwise
// [RULE12] overload shutdown held until reset
// [RULE13] latched mode trips on first event
// [RULE14] resistor picks mode and threshold
// [RULE15] out of range resistor gives minimum threshold
// [RULE16] controller holds reset until supplies settle
// [RULE17] controller lowers volume on warning
// [RULE18] counter maximum is 1024 frames
// [RULE19] thermal shutdown latches until reset
// [RULE20] reset release at least 4 ms after flag
// [RULE21] comparator flags sampled as synchronous inputs
`timescale 1ns/1ps

module apf_fault_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // device reset pin and frame timing
    input wire logic RESET_N,
    input wire logic FRAME_START,
    // analog comparator flags
    input wire logic [apf_pkg::HB_COUNT-1:0] OC_DET,
    input wire logic [apf_pkg::HB_COUNT-1:0] BOOTSTRAP_SUPPLY_UV,
    input wire logic THERMAL_WARNING,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic UNDERVOLT,
    // configuration
    input wire logic [1:0] MODE_SEL,
    input wire logic [apf_pkg::RES_W-1:0] OVERCURRENT_SELECT_RESISTOR,
    // power stage control
    output logic [apf_pkg::HB_COUNT-1:0] HB_HIZ,
    output logic [apf_pkg::HB_COUNT-1:0] HB_HS_OFF,
    output logic [apf_pkg::HB_COUNT-1:0] HB_FLIP,
    output logic [1:0] OC_THRESHOLD,
    output logic CYCLE_CURRENT_LIMIT,
    // open drain shutdown flag
    input wire logic SHUTDOWN_FLAG_N_I,
    output logic SHUTDOWN_FLAG_N_O,
    output logic SHUTDOWN_FLAG_N_OE,
    // open drain warning pin
    input wire logic CLIP_THERMAL_WARN_N_I,
    output logic CLIP_THERMAL_WARN_N_O,
    output logic CLIP_THERMAL_WARN_N_OE
);

    localparam int SYNC_W = 2 * apf_pkg::HB_COUNT + 4; // pins through the synchroniser

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] raw; // pins as they arrive
    logic [SYNC_W-1:0] sync1; // metastable stage, read only by sync2
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] filt; // accepted value
    logic [SYNC_W-1:0] next_filt;

    assign raw = {RESET_N, THERMAL_WARNING, THERMAL_SHUTDOWN, UNDERVOLT,
        BOOTSTRAP_SUPPLY_UV, OC_DET};

    // accept a bit only once the last two stages agree
    always_comb
    begin
        next_filt = filt;
        for (int i = 0; i < SYNC_W; i++)
        begin
            if (sync2[i] == sync3[i])
                next_filt[i] = sync3[i]; // [RULE21]
        end
    end

    // resets to all zero, so the device starts in reset
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt <= '0;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
        end
    end

    // unpacked views of the accepted flags
    logic [apf_pkg::HB_COUNT-1:0] oc;
    logic [apf_pkg::HB_COUNT-1:0] boot_uv;
    logic uv;
    logic tshut;
    logic twarn;
    logic dev_reset; // reset pin held low

    assign oc = filt[apf_pkg::HB_COUNT-1:0];
    assign boot_uv = filt[2*apf_pkg::HB_COUNT-1:apf_pkg::HB_COUNT];
    assign uv = filt[2*apf_pkg::HB_COUNT];
    assign tshut = filt[2*apf_pkg::HB_COUNT+1];
    assign twarn = filt[2*apf_pkg::HB_COUNT+2];
    assign dev_reset = ~filt[2*apf_pkg::HB_COUNT+3];

    // ------------------------------------------------------------
    // resistor decode
    // ------------------------------------------------------------
    // returns {latched mode, threshold code}
    function automatic logic [2:0] decode_res(input logic [apf_pkg::RES_W-1:0] r);
        logic [2:0] res;
        res = {1'b1, apf_pkg::THR_12A9};
        if (r >= apf_pkg::RES_CYC_LO && r <= apf_pkg::RES_CYC_HI)
        begin
            // lower band: cycle limiting
            if (r < apf_pkg::RES_CYC_2)
                res = {1'b0, apf_pkg::THR_17A0};
            else if (r < apf_pkg::RES_CYC_3)
                res = {1'b0, apf_pkg::THR_15A7};
            else if (r < apf_pkg::RES_CYC_HI)
                res = {1'b0, apf_pkg::THR_14A2};
            else
                res = {1'b0, apf_pkg::THR_12A9};
        end
        else if (r >= apf_pkg::RES_LAT_LO && r <= apf_pkg::RES_LAT_HI)
        begin
            // upper band: latched trip
            if (r < apf_pkg::RES_LAT_2)
                res = {1'b1, apf_pkg::THR_17A0};
            else if (r < apf_pkg::RES_LAT_3)
                res = {1'b1, apf_pkg::THR_15A7};
            else if (r < apf_pkg::RES_LAT_HI)
                res = {1'b1, apf_pkg::THR_14A2};
            else
                res = {1'b1, apf_pkg::THR_12A9};
        end
        return res;
    endfunction

    logic [2:0] oc_cfg;
    assign oc_cfg = decode_res(OVERCURRENT_SELECT_RESISTOR); // [RULE14] [RULE15] [RULE9]

    // ------------------------------------------------------------
    // half bridge limiters
    // ------------------------------------------------------------
    apf_hb_if hb_link[apf_pkg::HB_COUNT]();
    logic [apf_pkg::HB_COUNT-1:0] flip;
    logic [apf_pkg::HB_COUNT-1:0] overload;

    for (genvar g = 0; g < apf_pkg::HB_COUNT; g++)
    begin : g_hb
        // oc is masked during device reset so nothing counts
        assign hb_link[g].oc = oc[g] & ~dev_reset;
        assign hb_link[g].frame_start = FRAME_START;
        assign hb_link[g].latched_mode = oc_cfg[2];
        assign hb_link[g].clear = dev_reset;
        assign flip[g] = hb_link[g].flip;
        assign overload[g] = hb_link[g].overload;

        apf_hb_limiter u_limiter (
            .SYS_CLK(SYS_CLK),
            .RST(RST),
            .HB(hb_link[g])
        );
    end

    // ------------------------------------------------------------
    // thermal shutdown latch
    // ------------------------------------------------------------
    logic therm_latch;
    logic next_therm_latch;

    // held reset clears it; a hot die sets it again on release
    always_comb
    begin
        if (dev_reset)
            next_therm_latch = 1'b0; // [RULE19]
        else
            next_therm_latch = therm_latch | tshut; // [RULE19]
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            therm_latch <= 1'b0;
        else
            therm_latch <= next_therm_latch;
    end

    // ------------------------------------------------------------
    // shutdown mapping and registered outputs
    // ------------------------------------------------------------
    logic global_off; // every bridge off
    logic pair_ab; // a/b pair off
    logic pair_cd; // c/d pair off
    logic [apf_pkg::HB_COUNT-1:0] next_hiz;
    logic [apf_pkg::HB_COUNT-1:0] next_hs_off;
    logic [apf_pkg::HB_COUNT-1:0] next_flip_out;
    logic next_fault;
    logic next_warn;
    logic fault; // flag pulled low
    logic warn; // warning pulled low

    always_comb
    begin
        // undervoltage is not latched, so it drops out with the supply
        global_off = therm_latch | uv | dev_reset; // [RULE6] [RULE5]
        pair_ab = overload[apf_pkg::HB_A] | overload[apf_pkg::HB_B];
        pair_cd = overload[apf_pkg::HB_C] | overload[apf_pkg::HB_D];
        if (MODE_SEL == apf_pkg::MODE_PARALLEL)
        begin
            // one mono channel: any error takes all four
            pair_ab = |overload; // [RULE7]
            pair_cd = |overload; // [RULE7]
        end
        next_hiz = {pair_cd, pair_cd, pair_ab, pair_ab}
            | {apf_pkg::HB_COUNT{global_off}}; // [RULE7] [RULE5]
        // bootstrap undervoltage only kills its own high side
        next_hs_off = boot_uv & ~next_hiz; // [RULE8]
        // flip is meaningless once the bridge is off
        next_flip_out = flip & ~next_hiz; // [RULE10]
        // reset masks every fault on the flag
        next_fault = ~dev_reset & (therm_latch | uv | (|overload)); // [RULE1] [RULE4] [RULE3]
        next_warn = twarn; // [RULE2] [RULE3]
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            HB_HIZ <= '1;
            HB_HS_OFF <= '0;
            HB_FLIP <= '0;
            OC_THRESHOLD <= apf_pkg::THR_12A9;
            CYCLE_CURRENT_LIMIT <= 1'b0;
            fault <= 1'b0;
            warn <= 1'b0;
        end
        else
        begin
            HB_HIZ <= next_hiz;
            HB_HS_OFF <= next_hs_off;
            HB_FLIP <= next_flip_out;
            OC_THRESHOLD <= oc_cfg[1:0]; // [RULE14]
            CYCLE_CURRENT_LIMIT <= ~oc_cfg[2]; // [RULE9]
            fault <= next_fault;
            warn <= next_warn;
        end
    end

    // open drain: only ever pull low
    assign SHUTDOWN_FLAG_N_O = 1'b0;
    assign SHUTDOWN_FLAG_N_OE = fault; // [RULE1]
    assign CLIP_THERMAL_WARN_N_O = 1'b0;
    assign CLIP_THERMAL_WARN_N_OE = warn; // [RULE2]

endmodule // apf_fault_top

// ==== common/apf_pkg.sv ====
package apf_pkg;

    // ------------------------------------------------------------
    // half bridge indexing and widths
    // ------------------------------------------------------------
    localparam int HB_COUNT = 4; // half bridges a, b, c, d
    localparam int HB_A = 0;
    localparam int HB_B = 1;
    localparam int HB_C = 2;
    localparam int HB_D = 3;
    localparam int RES_W = 7; // resistor setting in kilo-ohm, whole units

    // ------------------------------------------------------------
    // output configuration codes on the mode pins
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_BRIDGED = 2'h0; // bridged stereo
    localparam logic [1:0] MODE_PARALLEL = 2'h2; // parallel bridged mono
    localparam logic [1:0] MODE_SINGLE = 2'h3; // four single ended

    // ------------------------------------------------------------
    // overcurrent select resistor table, kilo-ohm
    // ------------------------------------------------------------
    localparam logic [RES_W-1:0] RES_CYC_LO = 7'h16; // 22k, 17.0 A
    localparam logic [RES_W-1:0] RES_CYC_2 = 7'h18; // 24k, 15.7 A
    localparam logic [RES_W-1:0] RES_CYC_3 = 7'h1B; // 27k, 14.2 A
    localparam logic [RES_W-1:0] RES_CYC_HI = 7'h1E; // 30k, 12.9 A
    localparam logic [RES_W-1:0] RES_LAT_LO = 7'h2F; // 47k, 17.0 A
    localparam logic [RES_W-1:0] RES_LAT_2 = 7'h33; // 51k, 15.7 A
    localparam logic [RES_W-1:0] RES_LAT_3 = 7'h38; // 56k, 14.2 A
    localparam logic [RES_W-1:0] RES_LAT_HI = 7'h40; // 64k, 12.9 A

    // threshold codes driven to the comparator reference
    localparam logic [1:0] THR_17A0 = 2'h0;
    localparam logic [1:0] THR_15A7 = 2'h1;
    localparam logic [1:0] THR_14A2 = 2'h2;
    localparam logic [1:0] THR_12A9 = 2'h3; // also the minimum threshold

    // ------------------------------------------------------------
    // overload counter
    // ------------------------------------------------------------
    localparam int OVL_W = 11;
    localparam logic [OVL_W-1:0] OVL_MAX = 11'h400; // 1024 frames
    localparam logic [OVL_W-1:0] OVL_ONE = 11'h001;
    localparam logic [OVL_W-1:0] OVL_ZERO = 11'h000;

endpackage

// ==== common/apf_hb_if.sv ====
`timescale 1ns/1ps

// links the protection core to one half bridge limiter
interface apf_hb_if;
    logic oc; // filtered overcurrent comparator
    logic frame_start; // first cycle of a pwm frame
    logic latched_mode; // latched overcurrent selected
    logic clear; // device reset held
    logic flip; // cycle limit flip state
    logic overload; // latched overload shutdown

    modport core (output oc, output frame_start, output latched_mode, output clear,
        input flip, input overload);
    modport limiter (input oc, input frame_start, input latched_mode, input clear,
        output flip, output overload);
endinterface

// ==== verilog/apf_hb_limiter.sv ====
`timescale 1ns/1ps

// one half bridge: cycle limiter, overload counter, latched trip
module apf_hb_limiter (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // core link
    apf_hb_if.limiter HB
);

    logic flip; // flip state in this frame
    logic seen_oc; // an event happened in this frame
    logic [apf_pkg::OVL_W-1:0] count; // overload counter
    logic overload; // latched shutdown
    logic next_flip;
    logic next_seen_oc;
    logic [apf_pkg::OVL_W-1:0] next_count;
    logic next_overload;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_flip = flip;
        next_seen_oc = seen_oc;
        next_count = count;
        next_overload = overload;
        if (HB.clear)
        begin
            // device reset wipes every latch and count
            next_flip = 1'b0; // [RULE12]
            next_seen_oc = 1'b0;
            next_count = apf_pkg::OVL_ZERO;
            next_overload = 1'b0; // [RULE12]
        end
        else if (HB.latched_mode)
        begin
            // first event trips at once, nothing counted
            next_flip = 1'b0;
            next_overload = overload | HB.oc; // [RULE13]
        end
        else
        begin
            // flip clears at frame start, but a new event wins
            if (HB.frame_start)
                next_flip = 1'b0; // [RULE10]
            if (HB.oc)
                next_flip = 1'b1; // [RULE10]
            if (HB.frame_start)
            begin
                // settle the frame just ended: up on event, down otherwise
                next_seen_oc = HB.oc;
                if (seen_oc)
                begin
                    if (count != apf_pkg::OVL_MAX)
                        next_count = count + apf_pkg::OVL_ONE; // [RULE11]
                end
                else if (count != apf_pkg::OVL_ZERO)
                begin
                    next_count = count - apf_pkg::OVL_ONE; // [RULE11]
                end
            end
            else
            begin
                next_seen_oc = seen_oc | HB.oc;
            end
            // saturated count means sustained overload
            next_overload = overload | (next_count == apf_pkg::OVL_MAX); // [RULE11] [RULE18]
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            flip <= 1'b0;
            seen_oc <= 1'b0;
            count <= apf_pkg::OVL_ZERO;
            overload <= 1'b0;
        end
        else
        begin
            flip <= next_flip;
            seen_oc <= next_seen_oc;
            count <= next_count;
            overload <= next_overload;
        end
    end

    assign HB.flip = flip;
    assign HB.overload = overload;

endmodule // apf_hb_limiter

// ==== dv/apf_fault_props.sv ====
`timescale 1ns/1ps
// --------------------------------
// status pin and bridge checker
// --------------------------------
module apf_fault_props (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // pins in
    input wire logic RESET_N,
    input wire logic FRAME_START,
    input wire logic [apf_pkg::HB_COUNT-1:0] OC_DET,
    input wire logic THERMAL_WARNING,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic UNDERVOLT,
    input wire logic [apf_pkg::RES_W-1:0] OVERCURRENT_SELECT_RESISTOR,
    // pins out
    input wire logic [apf_pkg::HB_COUNT-1:0] HB_HIZ,
    input wire logic [apf_pkg::HB_COUNT-1:0] HB_FLIP,
    input wire logic [1:0] OC_THRESHOLD,
    input wire logic CYCLE_CURRENT_LIMIT,
    input wire logic SHUTDOWN_FLAG_N_O,
    input wire logic SHUTDOWN_FLAG_N_OE,
    input wire logic CLIP_THERMAL_WARN_N_O,
    input wire logic CLIP_THERMAL_WARN_N_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // expected {cycle mode, threshold}; out of band falls to latched minimum
    function automatic logic [2:0] cfg(input logic [6:0] r);
        if (r >= 7'h16 && r <= 7'h1E)
            return {1'b1, r < 7'h18 ? 2'h0 : r < 7'h1B ? 2'h1 : r < 7'h1E ? 2'h2 : 2'h3};
        if (r >= 7'h2F && r <= 7'h40)
            return {1'b0, r < 7'h33 ? 2'h0 : r < 7'h38 ? 2'h1 : r < 7'h40 ? 2'h2 : 2'h3};
        return 3'h3;
    endfunction
    // six samples cover the three stage filter with margin
    sequence s_uv; (UNDERVOLT && RESET_N)[*6]; endsequence
    sequence s_rst; (!RESET_N)[*6]; endsequence
    sequence s_hot; (THERMAL_SHUTDOWN && RESET_N)[*6]; endsequence
    sequence s_lat; (!CYCLE_CURRENT_LIMIT && OC_DET[0] && RESET_N)[*6]; endsequence
    sequence s_quiet; (OC_DET == 4'h0 && !FRAME_START)[*6] ##1 FRAME_START; endsequence
    property p_uv; s_uv |=> SHUTDOWN_FLAG_N_OE && HB_HIZ == 4'hF; endproperty
    property p_rst; s_rst |=> !SHUTDOWN_FLAG_N_OE && HB_HIZ == 4'hF; endproperty
    property p_hot; s_hot |=> SHUTDOWN_FLAG_N_OE && HB_HIZ == 4'hF; endproperty
    property p_lat; s_lat |-> ##[1:2] (HB_HIZ[1:0] == 2'h3 && SHUTDOWN_FLAG_N_OE); endproperty
    property p_flip; s_quiet |-> ##2 HB_FLIP == 4'h0; endproperty
    property p_warn_on; THERMAL_WARNING[*6] |=> CLIP_THERMAL_WARN_N_OE; endproperty
    property p_warn_off; (!THERMAL_WARNING)[*6] |=> !CLIP_THERMAL_WARN_N_OE; endproperty
    // open drain pins only ever sink, and a flagged fault always has a bridge off
    property p_od;
        SHUTDOWN_FLAG_N_O == 1'b0 && CLIP_THERMAL_WARN_N_O == 1'b0
            && (!SHUTDOWN_FLAG_N_OE || HB_HIZ != 4'h0);
    endproperty
    property p_cfg;
        $stable(OVERCURRENT_SELECT_RESISTOR)[*3]
            |-> {CYCLE_CURRENT_LIMIT, OC_THRESHOLD} == cfg(OVERCURRENT_SELECT_RESISTOR);
    endproperty
    a_uv: assert property (p_uv) else $error("undervolt not reported");
    a_rst: assert property (p_rst) else $error("flag not released");
    a_hot: assert property (p_hot) else $error("thermal not reported");
    a_lat: assert property (p_lat) else $error("latched trip missing");
    a_flip: assert property (p_flip) else $error("flip not cleared");
    a_warn_on: assert property (p_warn_on) else $error("warning missing");
    a_warn_off: assert property (p_warn_off) else $error("warning stuck");
    a_od: assert property (p_od) else $error("pin driven high or fault without hi-z");
    a_cfg: assert property (p_cfg) else $error("bad threshold");
endmodule // apf_fault_props

bind apf_fault_top apf_fault_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .RESET_N(RESET_N),
    .FRAME_START(FRAME_START), .OC_DET(OC_DET), .THERMAL_WARNING(THERMAL_WARNING),
    .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .UNDERVOLT(UNDERVOLT),
    .OVERCURRENT_SELECT_RESISTOR(OVERCURRENT_SELECT_RESISTOR), .HB_HIZ(HB_HIZ),
    .HB_FLIP(HB_FLIP), .OC_THRESHOLD(OC_THRESHOLD), .CYCLE_CURRENT_LIMIT(CYCLE_CURRENT_LIMIT),
    .SHUTDOWN_FLAG_N_O(SHUTDOWN_FLAG_N_O), .SHUTDOWN_FLAG_N_OE(SHUTDOWN_FLAG_N_OE),
    .CLIP_THERMAL_WARN_N_O(CLIP_THERMAL_WARN_N_O),
    .CLIP_THERMAL_WARN_N_OE(CLIP_THERMAL_WARN_N_OE));

// ==== dv/apf_mcu_model.sv ====
`timescale 1ns/1ps
// --------------------------------
// system controller on the status pins
// --------------------------------
module apf_mcu_model #(
    parameter int HOLD = 16 // reset hold after flag fall, scaled down
) (
    // clock
    input wire logic clk,
    // open drain drive from the device
    input wire logic flag_o,
    input wire logic flag_oe,
    input wire logic warn_o,
    input wire logic warn_oe,
    // resolved pins and decisions
    output logic fault_n,
    output logic warn_n,
    output logic vol_down,
    output logic release_ok
);
    int since = HOLD; // cycles since the flag fell
    logic last_n = 1'b1; // flag level one cycle ago
    // pull-ups hold the lines high unless the device sinks them
    assign fault_n = flag_oe ? flag_o : 1'b1;
    assign warn_n = warn_oe ? warn_o : 1'b1;
    // back the volume off before heat forces shutdown
    assign vol_down = !warn_n;
    // release only once hold time passed and the part is cool
    assign release_ok = since >= HOLD && warn_n;
    // time from the latest falling edge of the flag
    always_ff @(posedge clk)
    begin
        last_n <= fault_n;
        since <= (last_n && !fault_n) ? 0 : (since < HOLD ? since + 1 : since);
    end
endmodule // apf_mcu_model

// ==== dv/tb_amp_protection_fault_logic.sv ====
`timescale 1ns/1ps
// --------------------------------
// bench for the protection block
// --------------------------------
module tb_amp_protection_fault_logic;
    // stimulus, all driven from time zero
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic RESET_N = 1'b0;
    logic FRAME_START = 1'b0;
    logic [3:0] OC_DET = 4'h0;
    logic [3:0] BOOTSTRAP_SUPPLY_UV = 4'h0;
    logic THERMAL_WARNING = 1'b0;
    logic THERMAL_SHUTDOWN = 1'b0;
    logic UNDERVOLT = 1'b0;
    logic [1:0] MODE_SEL = 2'h0;
    logic [6:0] OVERCURRENT_SELECT_RESISTOR = 7'h16;
    // results
    logic [3:0] HB_HIZ, HB_HS_OFF, HB_FLIP;
    logic [1:0] OC_THRESHOLD;
    logic CYCLE_CURRENT_LIMIT, flag_o, flag_oe, warn_o, warn_oe;
    logic fault_n, warn_n, vol_down, release_ok;
    int bad_count = 0;
    int comparisons = 0;
    // 40 MHz clock
    initial
    begin
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    apf_fault_top u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .RESET_N(RESET_N),
        .FRAME_START(FRAME_START), .OC_DET(OC_DET), .BOOTSTRAP_SUPPLY_UV(BOOTSTRAP_SUPPLY_UV),
        .THERMAL_WARNING(THERMAL_WARNING), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
        .UNDERVOLT(UNDERVOLT), .MODE_SEL(MODE_SEL),
        .OVERCURRENT_SELECT_RESISTOR(OVERCURRENT_SELECT_RESISTOR), .HB_HIZ(HB_HIZ),
        .HB_HS_OFF(HB_HS_OFF), .HB_FLIP(HB_FLIP), .OC_THRESHOLD(OC_THRESHOLD),
        .CYCLE_CURRENT_LIMIT(CYCLE_CURRENT_LIMIT), .SHUTDOWN_FLAG_N_I(fault_n),
        .SHUTDOWN_FLAG_N_O(flag_o), .SHUTDOWN_FLAG_N_OE(flag_oe),
        .CLIP_THERMAL_WARN_N_I(warn_n), .CLIP_THERMAL_WARN_N_O(warn_o),
        .CLIP_THERMAL_WARN_N_OE(warn_oe));
    apf_mcu_model u_mcu (.clk(SYS_CLK), .flag_o(flag_o), .flag_oe(flag_oe), .warn_o(warn_o),
        .warn_oe(warn_oe), .fault_n(fault_n), .warn_n(warn_n), .vol_down(vol_down),
        .release_ok(release_ok));
    task automatic step(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // both pins and the bridge state together
    task automatic st(input logic fn, input logic wn, input logic [3:0] hz, input string m);
        chk_bit(fault_n, fn, m);
        chk_bit(warn_n, wn, m);
        chk_vec(HB_HIZ, hz, m);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // eight cycle pwm frames
    task automatic frames(input int n);
        repeat (n)
        begin
            @(posedge SYS_CLK) FRAME_START <= 1'b1;
            @(posedge SYS_CLK) FRAME_START <= 1'b0;
            step(6);
        end
    endtask
    // toggle the reset pin; waiting on the controller keeps the hold time
    task automatic dev_reset();
        int i;
        @(posedge SYS_CLK) RESET_N <= 1'b0;
        step(8);
        chk_bit(fault_n, 1'b1, "flag held in reset");
        for (i = 0; i < 200 && release_ok !== 1'b1; i++)
            step(1);
        if (release_ok !== 1'b1)
        begin
            bad_count++;
            $display("MISMATCH %0t release wait", $time);
            finish_test();
        end
        @(posedge SYS_CLK) RESET_N <= 1'b1;
        step(8);
    endtask
    task automatic t_config();
        logic [6:0] r [10] = '{7'h16, 7'h18, 7'h1B, 7'h1E, 7'h2F, 7'h33, 7'h38, 7'h40,
            7'h1F, 7'h05};
        logic [2:0] e [10] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge SYS_CLK) OVERCURRENT_SELECT_RESISTOR <= r[i];
            step(3);
            chk_vec({1'b0, CYCLE_CURRENT_LIMIT, OC_THRESHOLD}, {1'b0, e[i]}, "cfg");
        end
        $display("test config done");
    endtask
    task automatic t_levels();
        @(posedge SYS_CLK) UNDERVOLT <= 1'b1;
        step(8);
        st(1'b0, 1'b1, 4'hF, "uv");
        THERMAL_WARNING <= 1'b1;
        step(8);
        st(1'b0, 1'b0, 4'hF, "uv and warn");
        chk_bit(vol_down, 1'b1, "volume not backed off");
        UNDERVOLT <= 1'b0;
        step(8);
        st(1'b1, 1'b0, 4'h0, "warn only");
        THERMAL_WARNING <= 1'b0;
        BOOTSTRAP_SUPPLY_UV <= 4'h2;
        step(8);
        chk_vec(HB_HS_OFF, 4'h2, "bst");
        st(1'b1, 1'b1, 4'h0, "bst no flag");
        chk_bit(vol_down, 1'b0, "volume held down");
        BOOTSTRAP_SUPPLY_UV <= 4'h0;
        step(8);
        chk_vec(HB_HS_OFF, 4'h0, "bst gone");
        THERMAL_SHUTDOWN <= 1'b1;
        step(8);
        THERMAL_SHUTDOWN <= 1'b0;
        step(8);
        st(1'b0, 1'b1, 4'hF, "thermal latch");
        dev_reset();
        st(1'b1, 1'b1, 4'h0, "thermal cleared");
        $display("test levels done");
    endtask
    task automatic t_latched();
        logic [1:0] md [3] = '{apf_pkg::MODE_BRIDGED, apf_pkg::MODE_SINGLE,
            apf_pkg::MODE_PARALLEL};
        logic [3:0] oc [3] = '{4'h1, 4'h4, 4'h1};
        logic [3:0] hz [3] = '{4'h3, 4'hC, 4'hF};
        @(posedge SYS_CLK) OVERCURRENT_SELECT_RESISTOR <= apf_pkg::RES_LAT_2;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge SYS_CLK) MODE_SEL <= md[i];
            OC_DET <= oc[i];
            step(8);
            OC_DET <= 4'h0;
            step(8);
            st(1'b0, 1'b1, hz[i], "latched trip");
            dev_reset();
            st(1'b1, 1'b1, 4'h0, "trip cleared");
        end
        $display("test latched done");
    endtask
    task automatic t_cycle();
        @(posedge SYS_CLK) OVERCURRENT_SELECT_RESISTOR <= apf_pkg::RES_CYC_3;
        MODE_SEL <= apf_pkg::MODE_BRIDGED;
        frames(2);
        OC_DET <= 4'h2;
        step(7);
        chk_vec(HB_FLIP, 4'h2, "flip set");
        OC_DET <= 4'h0;
        frames(2);
        chk_vec(HB_FLIP, 4'h0, "flip cleared");
        OC_DET <= 4'h8;
        frames(1010);
        st(1'b1, 1'b1, 4'h0, "still limiting");
        OC_DET <= 4'h0;
        frames(12);
        OC_DET <= 4'h8;
        frames(20);
        st(1'b1, 1'b1, 4'h0, "count went down");
        frames(20);
        st(1'b0, 1'b1, 4'hC, "overload");
        OC_DET <= 4'h0;
        dev_reset();
        st(1'b1, 1'b1, 4'h0, "overload cleared");
        $display("test cycle done");
    endtask
    initial
    begin
        step(3);
        RST <= 1'b0;
        step(20);
        RESET_N <= 1'b1;
        step(8);
        t_config();
        t_levels();
        t_latched();
        t_cycle();
        finish_test();
    end
endmodule // tb_amp_protection_fault_logic
